// ==== rtl/bsts_params.svh ====
`ifndef BSTS_PARAMS_SVH
`define BSTS_PARAMS_SVH

`define BSTS_DW 16
`define BSTS_AW 8

`define BSTS_OFF_CTRL 8'h00
`define BSTS_OFF_INTERVAL 8'h04
`define BSTS_OFF_COUNTDOWN 8'h08
`define BSTS_OFF_DURATION 8'h0C
`define BSTS_OFF_STATUS 8'h10
`define BSTS_OFF_ELAPSED 8'h14

`define BSTS_CTRL_START 0
`define BSTS_CTRL_STOP 1
`define BSTS_CTRL_DEFER 2
`define BSTS_CTRL_DEFAULTS 3

`define BSTS_ST_BUSY 0
`define BSTS_ST_STANDBY 1
`define BSTS_ST_ALARM 2
`define BSTS_ST_DEFER 3
`define BSTS_ST_PASS 4
`define BSTS_ST_FAIL 5
`define BSTS_ST_STOP 6
`define BSTS_ST_AUTO 7
`define BSTS_ST_ENABLED 8

`define BSTS_IN_BUTTON 0
`define BSTS_IN_REMOTE 1
`define BSTS_IN_PRESENT 2
`define BSTS_IN_BREAKER 3
`define BSTS_IN_DISCH 4
`define BSTS_IN_LOW 5
`define BSTS_IN_SBY_OK 6
`define BSTS_IN_OUT_OK 7
`define BSTS_IN_INVERTER 8
`define BSTS_IN_N 9

`define BSTS_RST_INTERVAL 16'h001E
`define BSTS_RST_COUNTDOWN 16'h001E
`define BSTS_RST_DURATION 16'h000A
`define BSTS_DEFER_DAYS 16'h0007
`define BSTS_INV_DEFER_MIN 8'h05
`define BSTS_CLEAR_MIN 16'h0001

`endif

// ==== rtl/bsts_pkg.sv ====
`include "bsts_params.svh"

package bsts_pkg;

  typedef enum logic [1:0] {
    BSTS_IDLE,
    BSTS_CHECK,
    BSTS_RUN
  } bsts_state_t;

  typedef struct packed {
    logic [`BSTS_DW-1:0] interval;
    logic [`BSTS_DW-1:0] countdown;
    logic defer_active;
    logic due;
  } bsts_sched_t;

  typedef struct packed {
    bsts_state_t state;
    logic [`BSTS_IN_N-1:0] s1;
    logic [`BSTS_IN_N-1:0] s2;
    logic [`BSTS_IN_N-1:0] s3;
    logic [`BSTS_IN_N-1:0] filt;
    logic [`BSTS_DW-1:0] duration;
    logic [`BSTS_DW-1:0] run_min;
    logic [7:0] inv_min;
    logic inv_deferred;
    logic alarm;
    logic last_pass;
    logic last_fail;
    logic last_stop;
    logic auto_run;
    logic [31:0] rdata;
  } bsts_top_t;

endpackage : bsts_pkg

// ==== rtl/bsts_if.sv ====
`timescale 1ns/10ps

`include "bsts_params.svh"

interface bsts_if;
  logic day_tick;
  logic int_wr;
  logic cnt_wr;
  logic defaults;
  logic defer_req;
  logic start_taken;
  logic [`BSTS_DW-1:0] wdata;
  logic [`BSTS_DW-1:0] interval;
  logic [`BSTS_DW-1:0] countdown;
  logic auto_due;
  logic defer_active;

  modport ctl (
    output day_tick,
    output int_wr,
    output cnt_wr,
    output defaults,
    output defer_req,
    output start_taken,
    output wdata,
    input interval,
    input countdown,
    input auto_due,
    input defer_active
  );

  modport sch (
    input day_tick,
    input int_wr,
    input cnt_wr,
    input defaults,
    input defer_req,
    input start_taken,
    input wdata,
    output interval,
    output countdown,
    output auto_due,
    output defer_active
  );
endinterface : bsts_if

// ==== rtl/bsts_sched.sv ====
`timescale 1ns/10ps

`include "bsts_params.svh"

module bsts_sched (
  input wire logic clk,
  input wire logic rst,
  bsts_if.sch bus
);

  localparam bsts_pkg::bsts_sched_t SCHED_RST = '{
    interval: `BSTS_RST_INTERVAL,
    countdown: `BSTS_RST_COUNTDOWN,
    default: '0
  };

  bsts_pkg::bsts_sched_t q;
  bsts_pkg::bsts_sched_t d;

  always_comb begin
    d = q;
    d.due = 1'b0;
    if (bus.defaults) begin
      d = SCHED_RST;
    end else begin
      if (bus.int_wr) begin
        d.interval = bus.wdata;
        // re-enabling restarts the countdown from the new interval
        if (q.interval == '0 && bus.wdata != '0) begin
          d.countdown = bus.wdata;
        end
      end
      if (bus.cnt_wr) begin
        d.countdown = bus.wdata;
      end
      // zero interval freezes the whole schedule
      if (d.interval != '0) begin
        if (bus.day_tick && d.countdown != '0) begin
          d.countdown = d.countdown - 16'h0001;
        end
        // a defer only moves a test that falls inside the coming week
        if (bus.defer_req && d.countdown < `BSTS_DEFER_DAYS) begin
          d.countdown = `BSTS_DEFER_DAYS;
          d.defer_active = 1'b1;
        end
        if (d.countdown == '0) begin
          d.due = 1'b1;
          d.countdown = d.interval;
          d.defer_active = 1'b0;
        end
      end
      if (bus.start_taken) begin
        d.defer_active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= SCHED_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.interval = q.interval;
  assign bus.countdown = q.countdown;
  assign bus.auto_due = q.due;
  assign bus.defer_active = q.defer_active;

endmodule : bsts_sched

// ==== rtl/bsts_top.sv ====
`timescale 1ns/10ps

// Function
// - second button press or menu stop ends a running test at once.
// - interval of zero days disables all scheduled tests.
// - writing a nonzero interval re-enables scheduling with that day count.
// - after reset tests are enabled with a 30 day interval.
// - battery must be present, breaker closed, charged before standby starts.
// - passing check enters standby for the programmed period, then returns.
// - pass needs normal standby, voltage above threshold, stable output throughout.
// - failure sets alarm; only a pass of at least one minute clears it.
// - a local manual start request launches a test.
// - a start from the remote monitoring card launches a test.
// - deferral touches only a test due within seven days.
// - repeated deferrals push the test seven days past the latest one.
// - deferral with no test in the coming week changes nothing.
// - a manual start runs despite, and cancels, a pending deferral.
// - a programmable day countdown to the next test, idle at zero interval.
// - standby length comes from a minute duration for every test.
// - more than 5 minutes on inverter raises a deferral by itself.
// - active deferral with under seven days left sets the countdown to seven days.

`include "bsts_params.svh"

module bsts_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [`BSTS_AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic DAY_TICK,
  input wire logic MINUTE_TICK,
  input wire logic TEST_BUTTON,
  input wire logic REMOTE_START,
  input wire logic BATT_PRESENT,
  input wire logic BATT_BREAKER_CLOSED,
  input wire logic BATT_DISCHARGED,
  input wire logic BATT_BELOW_THRESHOLD,
  input wire logic STANDBY_NORMAL,
  input wire logic OUTPUT_STABLE,
  input wire logic INVERTER_MODE,
  output logic STANDBY_REQ,
  output logic TEST_ACTIVE,
  output logic SELF_TEST_FAIL_ALARM
);

  localparam bsts_pkg::bsts_top_t TOP_RST = '{
    state: bsts_pkg::BSTS_IDLE,
    duration: `BSTS_RST_DURATION,
    default: '0
  };

  function automatic logic hit(input logic [`BSTS_AW-1:0] a, input logic [`BSTS_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  bsts_if sbus ();

  bsts_sched u_sched (
    .clk(CLK),
    .rst(RST),
    .bus(sbus)
  );

  bsts_pkg::bsts_top_t q;
  bsts_pkg::bsts_top_t d;

  logic [`BSTS_IN_N-1:0] pins;
  logic [`BSTS_IN_N-1:0] filt_next;
  logic [`BSTS_IN_N-1:0] rise;
  logic w_ctrl;
  logic cmd_start;
  logic cmd_stop;
  logic inv_defer;
  logic batt_ok;
  logic run_fault;
  logic start_taken;

  assign pins[`BSTS_IN_BUTTON] = TEST_BUTTON;
  assign pins[`BSTS_IN_REMOTE] = REMOTE_START;
  assign pins[`BSTS_IN_PRESENT] = BATT_PRESENT;
  assign pins[`BSTS_IN_BREAKER] = BATT_BREAKER_CLOSED;
  assign pins[`BSTS_IN_DISCH] = BATT_DISCHARGED;
  assign pins[`BSTS_IN_LOW] = BATT_BELOW_THRESHOLD;
  assign pins[`BSTS_IN_SBY_OK] = STANDBY_NORMAL;
  assign pins[`BSTS_IN_OUT_OK] = OUTPUT_STABLE;
  assign pins[`BSTS_IN_INVERTER] = INVERTER_MODE;

  // a pin change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `BSTS_IN_N; gi++) begin : g_filt
      assign filt_next[gi] = (q.s2[gi] == q.s3[gi]) ? q.s2[gi] : q.filt[gi];
    end
  endgenerate

  assign rise = filt_next & ~q.filt;
  assign w_ctrl = WR && hit(ADDR, `BSTS_OFF_CTRL);

  // the button toggles: start when idle, stop otherwise
  assign cmd_start = (w_ctrl && WDATA[`BSTS_CTRL_START])
    || rise[`BSTS_IN_REMOTE]
    || (rise[`BSTS_IN_BUTTON] && q.state == bsts_pkg::BSTS_IDLE);
  assign cmd_stop = (w_ctrl && WDATA[`BSTS_CTRL_STOP])
    || (rise[`BSTS_IN_BUTTON] && q.state != bsts_pkg::BSTS_IDLE);

  assign inv_defer = !q.inv_deferred && (q.inv_min > `BSTS_INV_DEFER_MIN);

  assign batt_ok = q.filt[`BSTS_IN_PRESENT] && q.filt[`BSTS_IN_BREAKER]
    && !q.filt[`BSTS_IN_DISCH];
  assign run_fault = !q.filt[`BSTS_IN_SBY_OK] || q.filt[`BSTS_IN_LOW]
    || !q.filt[`BSTS_IN_OUT_OK];

  assign sbus.day_tick = DAY_TICK;
  assign sbus.int_wr = WR && hit(ADDR, `BSTS_OFF_INTERVAL);
  assign sbus.cnt_wr = WR && hit(ADDR, `BSTS_OFF_COUNTDOWN);
  assign sbus.defaults = w_ctrl && WDATA[`BSTS_CTRL_DEFAULTS];
  assign sbus.defer_req = (w_ctrl && WDATA[`BSTS_CTRL_DEFER]) || inv_defer;
  assign sbus.start_taken = start_taken;
  assign sbus.wdata = WDATA[`BSTS_DW-1:0];

  always_comb begin
    d = q;
    start_taken = 1'b0;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = filt_next;

    if (sbus.defaults) begin
      d.duration = `BSTS_RST_DURATION;
    end
    if (WR && hit(ADDR, `BSTS_OFF_DURATION)) begin
      d.duration = WDATA[`BSTS_DW-1:0];
    end

    // outage time on inverter, self tests excluded
    if (q.filt[`BSTS_IN_INVERTER] && q.state == bsts_pkg::BSTS_IDLE) begin
      if (MINUTE_TICK && q.inv_min != 8'hFF) begin
        d.inv_min = q.inv_min + 8'h01;
      end
      if (inv_defer) begin
        d.inv_deferred = 1'b1;
      end
    end else begin
      d.inv_min = 8'h00;
      d.inv_deferred = 1'b0;
    end

    unique case (q.state)
      bsts_pkg::BSTS_IDLE: begin
        // a due pulse arriving mid-test is dropped; next one is an interval later
        if (cmd_start || sbus.auto_due) begin
          d.state = bsts_pkg::BSTS_CHECK;
          d.run_min = '0;
          d.last_pass = 1'b0;
          d.last_fail = 1'b0;
          d.last_stop = 1'b0;
          d.auto_run = !cmd_start;
          start_taken = cmd_start;
        end
      end
      bsts_pkg::BSTS_CHECK: begin
        if (cmd_stop) begin
          d.state = bsts_pkg::BSTS_IDLE;
          d.last_stop = 1'b1;
        end else if (batt_ok) begin
          d.state = bsts_pkg::BSTS_RUN;
        end else begin
          // no inverter attempt without a usable battery
          d.state = bsts_pkg::BSTS_IDLE;
          d.alarm = 1'b1;
          d.last_fail = 1'b1;
        end
      end
      bsts_pkg::BSTS_RUN: begin
        if (cmd_stop) begin
          d.state = bsts_pkg::BSTS_IDLE;
          d.last_stop = 1'b1;
        end else if (run_fault) begin
          d.state = bsts_pkg::BSTS_IDLE;
          d.alarm = 1'b1;
          d.last_fail = 1'b1;
        end else if (q.run_min >= q.duration) begin
          d.state = bsts_pkg::BSTS_IDLE;
          d.last_pass = 1'b1;
          // a zero-length pass is too short to clear the alarm
          if (q.run_min >= `BSTS_CLEAR_MIN) begin
            d.alarm = 1'b0;
          end
        end else if (MINUTE_TICK) begin
          d.run_min = q.run_min + 16'h0001;
        end
      end
    endcase

    d.rdata = '0;
    if (RD) begin
      if (hit(ADDR, `BSTS_OFF_INTERVAL)) begin
        d.rdata[`BSTS_DW-1:0] = sbus.interval;
      end else if (hit(ADDR, `BSTS_OFF_COUNTDOWN)) begin
        d.rdata[`BSTS_DW-1:0] = sbus.countdown;
      end else if (hit(ADDR, `BSTS_OFF_DURATION)) begin
        d.rdata[`BSTS_DW-1:0] = q.duration;
      end else if (hit(ADDR, `BSTS_OFF_ELAPSED)) begin
        d.rdata[`BSTS_DW-1:0] = q.run_min;
      end else if (hit(ADDR, `BSTS_OFF_STATUS)) begin
        d.rdata[`BSTS_ST_BUSY] = q.state != bsts_pkg::BSTS_IDLE;
        d.rdata[`BSTS_ST_STANDBY] = q.state == bsts_pkg::BSTS_RUN;
        d.rdata[`BSTS_ST_ALARM] = q.alarm;
        d.rdata[`BSTS_ST_DEFER] = sbus.defer_active;
        d.rdata[`BSTS_ST_PASS] = q.last_pass;
        d.rdata[`BSTS_ST_FAIL] = q.last_fail;
        d.rdata[`BSTS_ST_STOP] = q.last_stop;
        d.rdata[`BSTS_ST_AUTO] = q.auto_run;
        d.rdata[`BSTS_ST_ENABLED] = sbus.interval != '0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign STANDBY_REQ = q.state == bsts_pkg::BSTS_RUN;
  assign TEST_ACTIVE = q.state != bsts_pkg::BSTS_IDLE;
  assign SELF_TEST_FAIL_ALARM = q.alarm;

endmodule : bsts_top

// ==== bench/bsts_properties.sv ====
`timescale 1ns/10ps

module bsts_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic BATT_PRESENT,
  input wire logic STANDBY_REQ,
  input wire logic TEST_ACTIVE,
  input wire logic SELF_TEST_FAIL_ALARM
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);

  wire ctl = WR && ADDR == 8'h00;

  // agree filter holds on a split pair, so one of the last two samples must be high
  AST_SBY_BATT: assert property ($rose(STANDBY_REQ) |->
    $past(TEST_ACTIVE) && ($past(BATT_PRESENT, 4) || $past(BATT_PRESENT, 5)))
    else $error("standby no battery");
  AST_SBY_TEST: assert property (STANDBY_REQ |-> TEST_ACTIVE)
    else $error("standby idle");
  AST_SBY_END: assert property ($fell(STANDBY_REQ) |-> !TEST_ACTIVE)
    else $error("standby end");
  AST_ALM_SET: assert property ($rose(SELF_TEST_FAIL_ALARM) |-> $fell(TEST_ACTIVE))
    else $error("alarm set");
  AST_ALM_CLR: assert property ($fell(SELF_TEST_FAIL_ALARM) |-> $fell(STANDBY_REQ))
    else $error("alarm clear");
  AST_START: assert property (ctl && WDATA[0] && !TEST_ACTIVE |=> TEST_ACTIVE)
    else $error("no start");
  AST_STOP: assert property (ctl && WDATA[1] && STANDBY_REQ |=> !TEST_ACTIVE)
    else $error("no stop");
  AST_STOP_ALM: assert property (ctl && WDATA[1] && STANDBY_REQ |=>
    $stable(SELF_TEST_FAIL_ALARM) [*2]) else $error("stop moved alarm");
endmodule : bsts_properties

bind bsts_top bsts_properties u_prop (.CLK(CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .BATT_PRESENT(BATT_PRESENT), .STANDBY_REQ(STANDBY_REQ),
  .TEST_ACTIVE(TEST_ACTIVE), .SELF_TEST_FAIL_ALARM(SELF_TEST_FAIL_ALARM));

// ==== bench/bsts_panel.sv ====
`timescale 1ns/10ps

module bsts_panel (
  input wire logic clk,
  output logic button,
  output logic remote,
  output logic [6:0] hv
);
  initial begin
    button = 1'b0;
    remote = 1'b0;
    hv = 7'h66;
  end

  // held 8 cycles so the agree filter takes it
  task automatic press(input logic card);
    @(posedge clk);
    if (card) remote <= 1'b1;
    else button <= 1'b1;
    repeat (8) @(posedge clk);
    remote <= 1'b0;
    button <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press

  task automatic health(input logic [6:0] v);
    @(posedge clk);
    hv <= v;
    repeat (8) @(posedge clk);
  endtask : health
endmodule : bsts_panel

// ==== bench/test_battery_self_test_scheduler.sv ====
`timescale 1ns/10ps

module test_battery_self_test_scheduler;
  logic clk = 1'b0;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en, rd_en, day_t, min_t;
  logic [31:0] rdata;
  logic sby, act, alm, btn, rem;
  logic [6:0] hv;
  logic [6:0] bad [6] = '{7'h6E, 7'h64, 7'h62, 7'h26, 7'h46, 7'h76};
  localparam logic [31:0] FM = 32'hFFFFFFFF;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  bsts_panel u_pnl (.clk(clk), .button(btn), .remote(rem), .hv(hv));

  bsts_top u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en),
    .RDATA(rdata), .DAY_TICK(day_t), .MINUTE_TICK(min_t), .TEST_BUTTON(btn),
    .REMOTE_START(rem), .BATT_PRESENT(hv[6]), .BATT_BREAKER_CLOSED(hv[5]),
    .BATT_DISCHARGED(hv[4]), .BATT_BELOW_THRESHOLD(hv[3]), .STANDBY_NORMAL(hv[2]),
    .OUTPUT_STABLE(hv[1]), .INVERTER_MODE(hv[0]), .STANDBY_REQ(sby), .TEST_ACTIVE(act),
    .SELF_TEST_FAIL_ALARM(alm));

  task end_sim();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= {16'h0, d};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rc

  task tick(input logic m, input int n);
    repeat (n) begin
      @(posedge clk);
      if (m) min_t <= 1'b1;
      else day_t <= 1'b1;
      @(posedge clk);
      min_t <= 1'b0;
      day_t <= 1'b0;
    end
  endtask : tick

  task wt(input logic v);
    int i;
    #1;
    for (i = 0; i < 40 && act !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(act), 32'(v));
  endtask : wt

  // button and card starts take 16 cycles, so short runs use the menu
  task run(input int h, input logic [15:0] m, input logic p);
    wr(8'h0C, m);
    if (h == 0) wr(8'h00, 16'h1);
    else u_pnl.press(h == 2);
    wt(1'b1);
    tick(1'b1, m);
    wt(1'b0);
    rc(8'h10, 32'h10, {27'h0, p, 4'h0});
    rc(8'h14, FM, p ? {16'h0, m} : 32'h0);
  endtask : run

  task t_reset();
    rc(8'h04, FM, 32'h1E);
    rc(8'h08, FM, 32'h1E);
    rc(8'h10, FM, 32'h100);
    rc(8'h20, FM, 32'h0);
  endtask : t_reset

  task t_pass();
    run(1, 16'h2, 1'b1);
    chk(32'(alm), 32'h0);
    for (int i = 0; i < 3; i++) begin
      u_pnl.health(bad[i]);
      run(0, 16'h3, 1'b0);
      chk(32'(alm), 32'h1);
    end
    u_pnl.health(7'h66);
    run(0, 16'h0, 1'b1);
    chk(32'(alm), 32'h1);
    for (int i = 3; i < 6; i++) begin
      run(2, 16'h1, 1'b1);
      chk(32'(alm), 32'h0);
      u_pnl.health(bad[i]);
      wr(8'h00, 16'h1);
      repeat (12) @(posedge clk);
      chk(32'(alm), 32'h1);
      u_pnl.health(7'h66);
    end
  endtask : t_pass

  task t_stop();
    wr(8'h0C, 16'h5);
    u_pnl.press(1'b0);
    wt(1'b1);
    chk(32'(sby), 32'h1);
    u_pnl.press(1'b0);
    wt(1'b0);
    chk(32'(sby), 32'h0);
    chk(32'(alm), 32'h1);
    rc(8'h10, 32'h40, 32'h40);
  endtask : t_stop

  task t_sched();
    wr(8'h04, 16'h0);
    rc(8'h10, 32'h100, 32'h0);
    wr(8'h08, 16'h1);
    tick(1'b0, 3);
    repeat (4) @(posedge clk);
    chk(32'(act), 32'h0);
    rc(8'h08, FM, 32'h1);
    wr(8'h04, 16'h2);
    rc(8'h08, FM, 32'h2);
    tick(1'b0, 1);
    rc(8'h08, FM, 32'h1);
    tick(1'b0, 1);
    wt(1'b1);
    rc(8'h08, FM, 32'h2);
    rc(8'h10, 32'h80, 32'h80);
    wr(8'h00, 16'h2);
    wt(1'b0);
  endtask : t_sched

  task t_defer();
    wr(8'h04, 16'h1E);
    wr(8'h08, 16'hA);
    wr(8'h00, 16'h4);
    rc(8'h08, FM, 32'hA);
    wr(8'h08, 16'h5);
    wr(8'h00, 16'h4);
    rc(8'h08, FM, 32'h7);
    rc(8'h10, 32'h8, 32'h8);
    tick(1'b0, 1);
    wr(8'h00, 16'h4);
    rc(8'h08, FM, 32'h7);
    wr(8'h00, 16'h1);
    wt(1'b1);
    rc(8'h10, 32'h8, 32'h0);
    wr(8'h00, 16'h2);
    wt(1'b0);
    wr(8'h08, 16'h3);
    u_pnl.health(7'h67);
    tick(1'b1, 5);
    rc(8'h08, FM, 32'h3);
    tick(1'b1, 1);
    repeat (4) @(posedge clk);
    rc(8'h08, FM, 32'h7);
    u_pnl.health(7'h66);
    wr(8'h04, 16'h5);
    wr(8'h0C, 16'h3);
    wr(8'h00, 16'h8);
    rc(8'h04, FM, 32'h1E);
    rc(8'h08, FM, 32'h1E);
    rc(8'h0C, FM, 32'hA);
    rc(8'h10, 32'h8, 32'h0);
    chk(32'(alm), 32'h1);
  endtask : t_defer

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    day_t = 1'b0;
    min_t = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pass();
    t_stop();
    t_sched();
    t_defer();
    end_sim();
  end
endmodule : test_battery_self_test_scheduler
